// ==== verif/panel_model.sv ====
// Panel model: takes one pixel step per rising panel clock.
// Assumes outputs have settled by the falling mclk edge.
`timescale 1ns/1ps
`default_nettype none
module panel_model (
  input wire logic mclk,
  input wire logic panel_pclk,
  input wire logic [1:0] pol,
  input wire logic line_sync,
  input wire logic frame_sync,
  input wire logic pixel_valid_enable,
  input wire logic [23:0] line_pixel_bus
);
  logic [23:0] got_q[$];
  logic pp = 1'b0, ls_p = 1'b0, fs_p = 1'b0;
  int px = 0, gap = 0, steps = 0, lines = 0, rows = 0;
  int line_px, line_pw, line_bp, line_tot, frame_rows, frame_tot;
  wire ls = line_sync ^ pol[0];
  wire fs = frame_sync ^ pol[1];
  // ----
  // Measure each line and frame; first figures after enable are partial
  // ----
  always @(negedge mclk) begin
    pp <= panel_pclk;
    if (panel_pclk && !pp) begin
      if (ls && !ls_p) begin
        if (px > 0) rows++;
        if (px > 0) line_px = px;
        line_tot = steps;
        lines++;
        px = 0;
        gap = 0;
        steps = 0;
      end
      if (fs && !fs_p) begin
        frame_rows = rows;
        frame_tot = lines;
        rows = 0;
        lines = 0;
      end
      if (ls_p && !ls) line_pw = steps;
      steps++;
      if (!ls && !pixel_valid_enable && px == 0) gap++;
      if (pixel_valid_enable) begin
        if (px == 0) line_bp = gap;
        px++;
        got_q.push_back(line_pixel_bus);
      end
      ls_p = ls;
      fs_p = fs;
    end
  end
endmodule
`default_nettype wire

// ==== verif/tft_panel_sync_timing_bench.sv ====
// Random bench for the panel timing generator with a panel model.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/1ps
`default_nettype none
module tft_panel_sync_timing_bench;
  logic mclk = 1'b0, rst_b = 1'b0, pix = 1'b0, en = 1'b0, inv = 1'b0;
  logic [11:0] aw = 12'h004, ah = 12'h002, lpw = 12'h001, lbp = 12'h001;
  logic [11:0] lfp = 12'h001, fpw = 12'h001, fbp = 12'h001, ffp = 12'h001;
  logic [1:0] pol = 2'h0;
  logic [3:0] dly = 4'h0;
  logic [7:0] r = 8'h00, g = 8'h00, b = 8'h00;
  logic sv = 1'b0, feed = 1'b0, xfer = 1'b0, dp;
  wire sr, pclk, ls, fs, de, ur;
  wire [23:0] bus;
  logic [23:0] exp_q[$];
  int errors = 0, cmp_count = 0, sent = 0, n;
  tft_panel_sync_timing uut (.mclk(mclk), .rst_b(rst_b), .pix_clk_in(pix), .display_enable(en),
    .active_width(aw), .active_height(ah), .line_pulse_width(lpw), .line_back_porch(lbp),
    .line_front_porch(lfp), .frame_pulse_width(fpw), .frame_back_porch(fbp),
    .frame_front_porch(ffp), .sync_polarity_setting(pol), .pclk_invert(inv), .pclk_delay(dly),
    .src_red(r), .src_green(g), .src_blue(b), .src_valid(sv), .src_ready(sr), .panel_pclk(pclk),
    .line_sync(ls), .frame_sync(fs), .pixel_valid_enable(de), .line_pixel_bus(bus),
    .underrun(ur));
  panel_model pm (.mclk(mclk), .panel_pclk(pclk), .pol(pol), .line_sync(ls), .frame_sync(fs),
    .pixel_valid_enable(de), .line_pixel_bus(bus));
  // ----
  // Clocks; the pixel clock is offset so its edges never meet mclk
  // ----
  initial forever #20 mclk = ~mclk;
  initial begin
    #7;
    forever #160 pix = ~pix;
  end
  // Source holds each word until the buffer takes it
  always @(posedge mclk) begin
    xfer <= sv && sr;
    if (sv && sr) exp_q.push_back({r, g, b});
    if (sv && sr) sent++;
  end
  always @(negedge mclk) if (!sv || xfer) begin
    sv = feed && ($urandom % 4 != 0);
    {r, g, b} = 24'($urandom);
  end
  task automatic note(input bit bad, input string what);
    cmp_count++;
    if (bad) begin
      errors++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    note(got !== exp, what);
  endtask
  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp, input string what);
    note(got !== exp, what);
  endtask
  task automatic chk_num(input int got, input int exp, input string what);
    note(got != exp, what);
  endtask
  // Zero pulse or active widths count as one
  function automatic int one_up(input logic [11:0] v);
    return (v == 12'h000) ? 1 : int'(v);
  endfunction
  function automatic int line_len();
    return one_up(lpw) + lbp + one_up(aw) + lfp;
  endfunction
  function automatic int frame_len();
    return one_up(fpw) + fbp + one_up(ah) + ffp;
  endfunction
  task automatic close_out;
    $display("compares %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----
  // Tests: idle and fill, polarity sweep, clock delay, underrun
  // ----
  initial begin
    n = $urandom(39);
    repeat (5) @(negedge mclk);
    rst_b = 1'b1;
    repeat (3) @(negedge mclk);
    chk_bit(ls, 1'b0, "idle line sync");
    chk_bit(fs, 1'b0, "idle frame sync");
    chk_bit(de, 1'b0, "idle enable");
    feed = 1'b1;
    for (n = 0; sr !== 1'b0 && n < 200; n++) @(negedge mclk);
    chk_bit(sent inside {[16:17]}, 1'b1, "buffer depth");
    $display("test fill done");
    for (int p = 0; p < 4; p++) begin
      en = 1'b0;
      // Let the synchronised enable drop before touching any setting
      repeat (4) @(negedge mclk);
      pol = 2'(p);
      aw = 12'(2 + $urandom % 4);
      lpw = 12'(1 + $urandom % 2);
      lbp = 12'(1 + $urandom % 3);
      lfp = 12'(1 + $urandom % 2);
      ah = 12'(2 + $urandom % 2);
      fpw = 12'(1 + p % 2);
      fbp = 12'(1 + $urandom % 2);
      ffp = 12'(1 + $urandom % 2);
      // Corner: zero pulse counts as one, zero back porch is legal
      if (p == 3) begin
        lpw = 12'h000;
        lbp = 12'h000;
      end
      repeat (10) @(negedge mclk);
      chk_bit(ls, pol[0], "parked line sync");
      chk_bit(fs, pol[1], "parked frame sync");
      en = 1'b1;
      repeat (16 * line_len() * frame_len() + 200) @(negedge mclk);
      chk_num(pm.line_px, aw, "active width");
      chk_num(pm.line_pw, one_up(lpw), "line pulse");
      chk_num(pm.line_bp, lbp, "back porch");
      chk_num(pm.line_tot, line_len(), "line length");
      chk_num(pm.frame_rows, ah, "active lines");
      chk_num(pm.frame_tot, frame_len(), "frame length");
      $display("test polarity %0d done", p);
    end
    chk_bit(pm.got_q.size() > 0, 1'b1, "no pixels");
    foreach (pm.got_q[i]) chk_word(pm.got_q[i], exp_q.pop_front(), "pixel data");
    for (int k = 0; k < 3; k++) begin
      en = 1'b0;
      dly = 4'(k + (k > 0));
      inv = (k != 1);
      repeat (20) @(negedge mclk);
      en = 1'b1;
      dp = 1'b1;
      repeat (2000) begin
        if (de && !dp) break;
        dp = de;
        @(negedge mclk);
      end
      for (n = 0; (pclk ^ inv) !== 1'b1 && n < 16; n++) @(negedge mclk);
      chk_num(n, dly, "clock delay");
    end
    en = 1'b0;
    {dly, inv} = 5'h00;
    $display("test clock delay done");
    repeat (10) @(negedge mclk);
    en = 1'b1;
    feed = 1'b0;
    for (n = 0; ur !== 1'b1 && n < 8000; n++) @(negedge mclk);
    chk_bit(ur, 1'b1, "no underrun");
    chk_bit(de, 1'b1, "underrun enable");
    chk_word(bus, 24'h000000, "underrun pixel");
    $display("test underrun done");
    close_out;
  end
  initial begin
    #3000000;
    errors++;
    $display("mismatch at %0t: watchdog", $time);
    close_out;
  end
endmodule
`default_nettype wire

// ==== verif/tft_sync_chk.sv ====
// Port checker for the panel timing generator.
// Assumes settings only change while the display is off.
`timescale 1ns/1ps
`default_nettype none
module tft_sync_chk (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic display_enable,
  input wire logic [1:0] sync_polarity_setting,
  input wire logic pclk_invert,
  input wire logic [3:0] pclk_delay,
  input wire logic panel_pclk,
  input wire logic line_sync,
  input wire logic frame_sync,
  input wire logic pixel_valid_enable,
  input wire logic [23:0] line_pixel_bus,
  input wire logic underrun
);
  // ----
  // Sync levels with polarity removed
  // ----
  wire ls = line_sync ^ sync_polarity_setting[0];
  wire fs = frame_sync ^ sync_polarity_setting[1];
  wire en = display_enable;
  wire plain = pclk_delay == 4'h0 && !pclk_invert;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // A disable may cut any interval short, so enable low excuses it
  de_vs_sync_a: assert property (pixel_valid_enable |-> !ls)
    else $error("data enable inside line sync");
  line_pulse_a: assert property ($rose(ls) |=> (ls || !en) [*5])
    else $error("line sync too short");
  frame_start_a: assert property ($rose(fs) && en |-> ls && !pixel_valid_enable)
    else $error("frame sync off a line start");
  frame_end_a: assert property ($fell(fs) && en && $past(en, 3) |-> $rose(ls))
    else $error("frame sync ended inside a line");
  pclk_edge_a:
    assert property (plain && en && $past(en, 4) && $changed(pixel_valid_enable)
      |-> $rose(panel_pclk)) else $error("outputs moved off the clock edge");
  pclk_run_a:
    assert property ((plain && en) [*8] |-> ##[0:4] ($changed(panel_pclk) || !en))
      else $error("pixel clock stopped");
  blank_data_a: assert property (!pixel_valid_enable |-> line_pixel_bus == 24'h000000)
    else $error("data outside enable");
  underrun_pulse_a: assert property (underrun |-> pixel_valid_enable ##1 !underrun)
    else $error("underrun pulse wrong");
  idle_sync_a:
    assert property ((!en) [*4] ##0 $stable(sync_polarity_setting) |-> !ls && !fs)
      else $error("idle sync level wrong");
endmodule
bind tft_panel_sync_timing tft_sync_chk chk (.mclk(mclk), .rst_b(rst_b),
  .display_enable(display_enable), .sync_polarity_setting(sync_polarity_setting),
  .pclk_invert(pclk_invert), .pclk_delay(pclk_delay), .panel_pclk(panel_pclk),
  .line_sync(line_sync), .frame_sync(frame_sync), .pixel_valid_enable(pixel_valid_enable),
  .line_pixel_bus(line_pixel_bus), .underrun(underrun));
`default_nettype wire

// ==== verilog/pixel_fifo.v ====
// Pixel buffer: small synchronous FIFO with a registered output stage.
// Assumes one clock (mclk) and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "tft_timing_defs.vh"

module pixel_fifo #(
  parameter WIDTH = `TFT_PIX_W,
  parameter DEPTH = `TFT_FIFO_DEPTH,
  parameter AW = `TFT_FIFO_AW
) (
  input wire mclk,
  input wire rst_b,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output reg in_ready,
  output reg [WIDTH-1:0] out_data,
  output reg out_valid,
  input wire out_ready
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  reg [AW:0] count_next;
  wire push;
  wire load;

  // ----------------------------------------------------------------
  // Handshake terms
  // ----------------------------------------------------------------
  // Output stage refills whenever it is empty or being taken and the array holds a word
  assign push = in_valid & in_ready;
  assign load = (~out_valid | out_ready) & (count_reg != {(AW+1){1'b0}});

  // Occupancy of the array, output stage not included
  always @* begin
    count_next = count_reg;
    if (push & ~load) begin
      count_next = count_reg + {{AW{1'b0}}, 1'b1};
    end else if (~push & load) begin
      count_next = count_reg - {{AW{1'b0}}, 1'b1};
    end
  end

  // Array write port; no reset, contents are don't-care until written
  always @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers, flags and registered read data
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      count_reg <= count_next;
      // Ready from a register: honest full, one cycle conservative
      in_ready <= (count_next < DEPTH[AW:0]) &&
                  !(push && (count_next == DEPTH[AW:0] - 1'b1));
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (load) begin
        out_data <= mem[rd_ptr_reg];
        out_valid <= 1'b1;
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ==== verilog/tft_panel_sync_timing.v ====
// Pixel-level timing generator for a parallel TFT panel.
// Assumes mclk at 25 MHz, a pixel rate clock from outside the mclk domain,
// a pixel stream on valid/ready, and static timing settings while enabled.
//
// Behaviour
// - Outputs change with rising pixel clock edge
// - Pixel clock runs continuously while display active
// - Line sync starts line, lasts line_pulse_width clocks, at least one
// - Frame sync spans at least one line sync
// - Data enable active high, marks valid pixels
// - Line/frame sync polarity selectable, default high
// - Pixel clock inversion and programmable delay
// - Sizes and porches from programmed settings
// - Pixel bus is red, green, blue bytes
`timescale 1ns/1ps
`default_nettype none
`include "tft_timing_defs.vh"

module tft_panel_sync_timing (
  input wire mclk,
  input wire rst_b,
  input wire pix_clk_in,
  input wire display_enable,
  input wire [`TFT_CNT_W-1:0] active_width,
  input wire [`TFT_CNT_W-1:0] active_height,
  input wire [`TFT_CNT_W-1:0] line_pulse_width,
  input wire [`TFT_CNT_W-1:0] line_back_porch,
  input wire [`TFT_CNT_W-1:0] line_front_porch,
  input wire [`TFT_CNT_W-1:0] frame_pulse_width,
  input wire [`TFT_CNT_W-1:0] frame_back_porch,
  input wire [`TFT_CNT_W-1:0] frame_front_porch,
  input wire [1:0] sync_polarity_setting,
  input wire pclk_invert,
  input wire [`TFT_DLY_W-1:0] pclk_delay,
  input wire [`TFT_COMP_W-1:0] src_red,
  input wire [`TFT_COMP_W-1:0] src_green,
  input wire [`TFT_COMP_W-1:0] src_blue,
  input wire src_valid,
  output wire src_ready,
  output reg panel_pclk,
  output reg line_sync,
  output reg frame_sync,
  output reg pixel_valid_enable,
  output reg [`TFT_PIX_W-1:0] line_pixel_bus,
  output reg underrun
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // A zero width would drop a phase; sync and active phases last at least one clock, porches may be zero
  function [`TFT_CNT_W-1:0] at_least_one;
    input [`TFT_CNT_W-1:0] v;
    begin
      at_least_one = (v == {`TFT_CNT_W{1'b0}}) ? {{(`TFT_CNT_W-1){1'b0}}, 1'b1} : v;
    end
  endfunction

  // Phase boundaries of one axis: end of sync, end of porch, end of active
  function [`TFT_CNT_W-1:0] bound;
    input [`TFT_CNT_W-1:0] a;
    input [`TFT_CNT_W-1:0] b;
    begin
      bound = a + b;
    end
  endfunction

  // ----------------------------------------------------------------
  // Pixel clock sampling
  // ----------------------------------------------------------------
  reg pclk_meta_reg;
  reg pclk_sync_reg;
  reg pclk_prev_reg;
  reg [`TFT_DLY_TAPS-1:0] pclk_tap_reg;
  reg en_meta_reg;
  reg en_sync_reg;
  wire pix_edge;

  // Two stages before anything reads the pin; the pixel clock must stay
  // below mclk/2, so 25 MHz sampling covers only the low end of 5..66 MHz
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pclk_meta_reg <= 1'b0;
      pclk_sync_reg <= 1'b0;
      pclk_prev_reg <= 1'b0;
      en_meta_reg <= 1'b0;
      en_sync_reg <= 1'b0;
      pclk_tap_reg <= {`TFT_DLY_TAPS{1'b0}};
    end else begin
      pclk_meta_reg <= pix_clk_in;
      pclk_sync_reg <= pclk_meta_reg;
      pclk_prev_reg <= pclk_sync_reg;
      en_meta_reg <= display_enable;
      en_sync_reg <= en_meta_reg;
      pclk_tap_reg <= {pclk_tap_reg[`TFT_DLY_TAPS-2:0], pclk_sync_reg};
    end
  end

  assign pix_edge = pclk_sync_reg & ~pclk_prev_reg;

  // Delayed, optionally inverted clock to the panel, gated only by enable
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      panel_pclk <= 1'b0;
    end else begin
      panel_pclk <= en_sync_reg &
                    ((pclk_delay == {`TFT_DLY_W{1'b0}} ? pclk_sync_reg :
                      pclk_tap_reg[pclk_delay - 1'b1]) ^ pclk_invert);
    end
  end

  // ----------------------------------------------------------------
  // Line and frame counters
  // ----------------------------------------------------------------
  reg [`TFT_CNT_W-1:0] h_cnt_reg;
  reg [`TFT_CNT_W-1:0] v_cnt_reg;
  reg [`TFT_CNT_W-1:0] h_cnt_next;
  reg [`TFT_CNT_W-1:0] v_cnt_next;
  wire [`TFT_CNT_W-1:0] h_sync_end;
  wire [`TFT_CNT_W-1:0] h_act_beg;
  wire [`TFT_CNT_W-1:0] h_act_end;
  wire [`TFT_CNT_W-1:0] h_total;
  wire [`TFT_CNT_W-1:0] v_sync_end;
  wire [`TFT_CNT_W-1:0] v_act_beg;
  wire [`TFT_CNT_W-1:0] v_act_end;
  wire [`TFT_CNT_W-1:0] v_total;
  wire h_active_next;
  wire v_active_next;
  wire de_next;

  // Sync, back porch, active area and front porch, in that order
  assign h_sync_end = at_least_one(line_pulse_width);
  assign h_act_beg = bound(h_sync_end, line_back_porch);
  assign h_act_end = bound(h_act_beg, at_least_one(active_width));
  assign h_total = bound(h_act_end, line_front_porch);
  assign v_sync_end = at_least_one(frame_pulse_width);
  assign v_act_beg = bound(v_sync_end, frame_back_porch);
  assign v_act_end = bound(v_act_beg, at_least_one(active_height));
  assign v_total = bound(v_act_end, frame_front_porch);

  // Next position; lines advance at the end of each line
  always @* begin
    h_cnt_next = h_cnt_reg + {{(`TFT_CNT_W-1){1'b0}}, 1'b1};
    v_cnt_next = v_cnt_reg;
    if (h_cnt_next >= h_total) begin
      h_cnt_next = {`TFT_CNT_W{1'b0}};
      v_cnt_next = v_cnt_reg + {{(`TFT_CNT_W-1){1'b0}}, 1'b1};
      if (v_cnt_next >= v_total) begin
        v_cnt_next = {`TFT_CNT_W{1'b0}};
      end
    end
  end

  assign h_active_next = (h_cnt_next >= h_act_beg) && (h_cnt_next < h_act_end);
  assign v_active_next = (v_cnt_next >= v_act_beg) && (v_cnt_next < v_act_end);
  assign de_next = h_active_next & v_active_next;

  // ----------------------------------------------------------------
  // Pixel buffer
  // ----------------------------------------------------------------
  wire [`TFT_PIX_W-1:0] fifo_data;
  wire fifo_valid;
  wire fifo_pop;

  // Only taken on an active pixel edge, so the source really stalls
  assign fifo_pop = en_sync_reg & pix_edge & de_next;

  pixel_fifo #(
    .WIDTH(`TFT_PIX_W),
    .DEPTH(`TFT_FIFO_DEPTH),
    .AW(`TFT_FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .in_data({src_red, src_green, src_blue}),
    .in_valid(src_valid),
    .in_ready(src_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // ----------------------------------------------------------------
  // Panel outputs
  // ----------------------------------------------------------------
  // Everything moves on the mclk cycle where the pixel clock rises, the
  // same cycle the undelayed panel clock rises, so the panel sees stable
  // data on its own rising edge
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      h_cnt_reg <= {`TFT_CNT_W{1'b0}};
      v_cnt_reg <= {`TFT_CNT_W{1'b0}};
      line_sync <= 1'b0;
      frame_sync <= 1'b0;
      pixel_valid_enable <= 1'b0;
      line_pixel_bus <= `TFT_PIX_RESET;
      underrun <= 1'b0;
    end else if (!en_sync_reg) begin
      // Idle: counters park at the last position so the first edge
      // starts a new line and frame
      h_cnt_reg <= h_total - {{(`TFT_CNT_W-1){1'b0}}, 1'b1};
      v_cnt_reg <= v_total - {{(`TFT_CNT_W-1){1'b0}}, 1'b1};
      line_sync <= sync_polarity_setting[`TFT_POL_LINE];
      frame_sync <= sync_polarity_setting[`TFT_POL_FRAME];
      pixel_valid_enable <= 1'b0;
      line_pixel_bus <= `TFT_PIX_RESET;
      underrun <= 1'b0;
    end else begin
      underrun <= 1'b0;
      if (pix_edge) begin
        h_cnt_reg <= h_cnt_next;
        v_cnt_reg <= v_cnt_next;
        // Frame pulse covers whole lines, so it spans their line pulses
        line_sync <= (h_cnt_next < h_sync_end) ^
                     sync_polarity_setting[`TFT_POL_LINE];
        frame_sync <= (v_cnt_next < v_sync_end) ^
                      sync_polarity_setting[`TFT_POL_FRAME];
        pixel_valid_enable <= de_next;
        // An empty buffer shows black and flags a one-cycle underrun
        if (de_next) begin
          line_pixel_bus <= fifo_valid ? fifo_data : `TFT_PIX_RESET;
          underrun <= ~fifo_valid;
        end else begin
          line_pixel_bus <= `TFT_PIX_RESET;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== verilog/tft_timing_defs.vh ====
// Constants shared by the panel timing generator and its pixel buffer.
// Assumes it is included by bare name from files under verilog/.
`ifndef TFT_TIMING_DEFS_VH
`define TFT_TIMING_DEFS_VH

// ----------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------
`define TFT_CNT_W 12
`define TFT_PIX_W 24
`define TFT_COMP_W 8
`define TFT_FIFO_DEPTH 16
`define TFT_FIFO_AW 4
`define TFT_DLY_W 4
`define TFT_DLY_TAPS 16

// ----------------------------------------------------------------
// Field positions of the sync polarity setting
// ----------------------------------------------------------------
`define TFT_POL_LINE 0
`define TFT_POL_FRAME 1

// ----------------------------------------------------------------
// Reset values and clock figures
// ----------------------------------------------------------------
`define TFT_POL_RESET 2'h0
`define TFT_PIX_RESET 24'h000000
`define TFT_MCLK_NS 40
`define TFT_PCLK_MIN_MHZ 5
`define TFT_PCLK_MAX_MHZ 66

`endif
